/* core/adcptc_pkg.sv */
package adcptc_pkg;
   // register byte addresses on the apb slave
   localparam logic [7:0] ADCPTC_OFF_CTL2 = 8'h00;
   localparam logic [7:0] ADCPTC_OFF_TRIGSEL = 8'h04;
   localparam logic [7:0] ADCPTC_OFF_STAT = 8'h08;
   localparam logic [7:0] ADCPTC_OFF_IRQ_STAT = 8'h0C;
   localparam logic [7:0] ADCPTC_OFF_IRQ_MASK = 8'h10;
   localparam logic [7:0] ADCPTC_OFF_RESULT = 8'h14;
   // control register bit positions
   localparam int ADCPTC_B_PWR = 7;
   localparam int ADCPTC_B_FAST_FLAG_CLEAR = 6;
   localparam int ADCPTC_B_WAIT_MODE_POWER_DOWN = 5;
   localparam int ADCPTC_B_TLE = 4;
   localparam int ADCPTC_B_TPOL = 3;
   localparam int ADCPTC_B_TEN = 2;
   localparam int ADCPTC_B_SIE = 1;
   localparam int ADCPTC_B_SIF = 0;
   // trigger select register
   localparam int ADCPTC_B_TSRC = 7;
   // irq status bits
   localparam int ADCPTC_I_SEQ = 0;
   localparam int ADCPTC_I_TRIG = 1;
   localparam int ADCPTC_I_ABORT = 2;
   localparam int ADCPTC_NIRQ = 3;
   localparam logic [7:0] ADCPTC_CTL2_RST = 8'h00;
   localparam logic [7:0] ADCPTC_TSEL_RST = 8'h00;

   typedef struct packed {
      logic [7:0] ctl;
      logic [7:0] tsel;
      logic [15:0] ccf;
      logic sequence_complete_flag;
      logic [15:0] stat_seen;
      logic busy;
      logic [ADCPTC_NIRQ-1:0] irq_stat;
      logic [ADCPTC_NIRQ-1:0] irq_mask;
      logic trig_s1;
      logic trig_s2;
      logic trig_d;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq;
      logic start;
      logic abort;
      logic pwr;
      logic [15:0] dig_en;
   } adcptc_state_t;
endpackage

/* core/adcptc_ctrl.sv */
`timescale 1ns/1ps
// Behaviour
// - any write to the control register aborts a running sequence, starts none
// - bit 7 clear powers converter down, set gives normal operation
// - fast clear off: flag clears on status read then result read
// - fast clear on: any result access clears that channel flag
// - bit 5 set halts and powers down in wait mode; clear keeps running
// - leaving wait resumes the conversion; software ignores first result
// - bits 4:3 select falling, rising, low level or high level trigger
// - bit 2 arms external trigger, which starts conversions from the source
// - armed trigger on an analog channel enables that channel input buffer
// - bit 1 set requests interrupt whenever sequence complete flag is set
// - bit 0 reads sequence complete when enabled, else zero; writes ignored
// - source is dedicated input when select set, else the chosen channel
module adcptc_ctrl
   import adcptc_pkg::*;
#(
   parameter int NCH = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [NCH-1:0] an_digital,
   input wire logic dedicated_trigger_input,
   input wire logic wait_mode,
   input wire logic conv_done,
   input wire logic [3:0] conv_ch,
   input wire logic seq_done,
   output logic conv_start,
   output logic conv_abort,
   output logic converter_power_on,
   output logic [NCH-1:0] digital_buffer_en,
   output logic irq
);
   initial begin
      if (NCH != 16) $error("adcptc_ctrl: NCH must be 16");
   end

   adcptc_state_t s_r, s_nxt;
   logic acc, wr, rd, trig_raw, trig_hit, run_ok;
   logic [ADCPTC_NIRQ-1:0] ev;
   logic [3:0] tch;
   // result window decode, shared by the flag clear checks
   logic res_acc;
   logic [3:0] res_idx;

   assign res_acc = paddr >= ADCPTC_OFF_RESULT &&
                    paddr < ADCPTC_OFF_RESULT + 8'h40;
   assign res_idx = paddr[5:2] - 4'h5;

   assign acc = psel && penable && !s_r.pready;

   always_comb begin
      s_nxt = s_r;
      wr = acc && pwrite;
      rd = acc && !pwrite;
      tch = s_r.tsel[3:0];
      ev = '0;
      s_nxt.pready = acc;
      s_nxt.pslverr = 1'b0;
      s_nxt.prdata = '0;
      s_nxt.start = 1'b0;
      s_nxt.abort = 1'b0;
      // two flops before any detection to avoid metastable decisions
      trig_raw = s_r.tsel[ADCPTC_B_TSRC] ? dedicated_trigger_input
                                          : an_digital[tch];
      s_nxt.trig_s1 = trig_raw;
      s_nxt.trig_s2 = s_r.trig_s1;
      s_nxt.trig_d = s_r.trig_s2;
      case ({s_r.ctl[ADCPTC_B_TLE], s_r.ctl[ADCPTC_B_TPOL]})
         2'b00: trig_hit = s_r.trig_d && !s_r.trig_s2;
         2'b01: trig_hit = !s_r.trig_d && s_r.trig_s2;
         2'b10: trig_hit = !s_r.trig_s2;
         default: trig_hit = s_r.trig_s2;
      endcase
      // wait-mode halt: power stays off until wait ends, then work resumes
      run_ok = s_r.ctl[ADCPTC_B_PWR]
               && !(wait_mode && s_r.ctl[ADCPTC_B_WAIT_MODE_POWER_DOWN]);
      s_nxt.pwr = run_ok;
      // level trigger only starts when idle, so it does not restart a run
      if (s_r.ctl[ADCPTC_B_TEN] && trig_hit && run_ok && !s_r.busy) begin
         s_nxt.start = 1'b1;
         s_nxt.busy = 1'b1;
         ev[ADCPTC_I_TRIG] = 1'b1;
      end
      s_nxt.dig_en = '0;
      if (s_r.ctl[ADCPTC_B_TEN] && !s_r.tsel[ADCPTC_B_TSRC])
         s_nxt.dig_en[tch] = 1'b1;
      if (conv_done && run_ok) begin
         s_nxt.ccf[conv_ch] = 1'b1;
         s_nxt.stat_seen[conv_ch] = 1'b0;
      end
      if (seq_done && run_ok) begin
         s_nxt.sequence_complete_flag = 1'b1;
         s_nxt.busy = 1'b0;
         ev[ADCPTC_I_SEQ] = 1'b1;
      end
      if (rd) begin
         if (paddr == ADCPTC_OFF_CTL2) begin
            s_nxt.prdata[7:0] = s_r.ctl;
            s_nxt.prdata[ADCPTC_B_SIF] =
               s_r.ctl[ADCPTC_B_SIE] && s_r.sequence_complete_flag;
         end else if (paddr == ADCPTC_OFF_TRIGSEL) begin
            s_nxt.prdata[7:0] = s_r.tsel;
         end else if (paddr == ADCPTC_OFF_STAT) begin
            s_nxt.prdata = {14'h0000, s_r.busy, s_r.sequence_complete_flag, s_r.ccf};
            s_nxt.stat_seen = s_r.ccf;
         end else if (paddr == ADCPTC_OFF_IRQ_STAT) begin
            s_nxt.prdata[ADCPTC_NIRQ-1:0] = s_r.irq_stat;
         end else if (paddr == ADCPTC_OFF_IRQ_MASK) begin
            s_nxt.prdata[ADCPTC_NIRQ-1:0] = s_r.irq_mask;
         end else if (paddr >= ADCPTC_OFF_RESULT &&
                      paddr < ADCPTC_OFF_RESULT + 8'h40) begin
            // result data lives elsewhere; this block only clears flags
            if (s_r.ctl[ADCPTC_B_FAST_FLAG_CLEAR] ||
                s_r.stat_seen[paddr[5:2] - 4'h5]) begin
               s_nxt.ccf[paddr[5:2] - 4'h5] = 1'b0;
               s_nxt.stat_seen[paddr[5:2] - 4'h5] = 1'b0;
               s_nxt.sequence_complete_flag = 1'b0;
            end
         end else begin
            s_nxt.pslverr = 1'b1;
         end
      end
      if (wr) begin
         if (paddr == ADCPTC_OFF_CTL2) begin
            // bit 0 is a read-only view of scf
            s_nxt.ctl = {pwdata[7:1], 1'b0};
            s_nxt.abort = 1'b1;
            s_nxt.busy = 1'b0;
            s_nxt.start = 1'b0;
            ev[ADCPTC_I_ABORT] = s_r.busy;
         end else if (paddr == ADCPTC_OFF_TRIGSEL) begin
            s_nxt.tsel = pwdata[7:0];
         end else if (paddr == ADCPTC_OFF_IRQ_STAT) begin
            s_nxt.irq_stat = s_r.irq_stat & ~pwdata[ADCPTC_NIRQ-1:0];
         end else if (paddr == ADCPTC_OFF_IRQ_MASK) begin
            s_nxt.irq_mask = pwdata[ADCPTC_NIRQ-1:0];
         end else if (paddr >= ADCPTC_OFF_RESULT &&
                      paddr < ADCPTC_OFF_RESULT + 8'h40) begin
            if (s_r.ctl[ADCPTC_B_FAST_FLAG_CLEAR]) begin
               s_nxt.ccf[paddr[5:2] - 4'h5] = 1'b0;
               s_nxt.sequence_complete_flag = 1'b0;
            end
         end else begin
            s_nxt.pslverr = 1'b1;
         end
      end
      // set wins over clear
      s_nxt.irq_stat = s_nxt.irq_stat | ev;
      s_nxt.irq = (|(s_nxt.irq_stat & s_nxt.irq_mask))
                  || (s_nxt.ctl[ADCPTC_B_SIE] && s_nxt.sequence_complete_flag);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata = s_r.prdata;
   assign pready = s_r.pready;
   assign pslverr = s_r.pslverr;
   assign conv_start = s_r.start;
   assign conv_abort = s_r.abort;
   assign converter_power_on = s_r.pwr;
   assign digital_buffer_en = s_r.dig_en;
   assign irq = s_r.irq;

   chk_write_aborts: assert property (@(posedge pclk) disable iff (!presetn)
      (acc && pwrite && paddr == ADCPTC_OFF_CTL2) |=> conv_abort && !conv_start)
      else $error("control write did not abort");
   chk_power_off: assert property (@(posedge pclk) disable iff (!presetn)
      !s_r.ctl[ADCPTC_B_PWR] |=> !converter_power_on)
      else $error("converter powered while bit clear");
   chk_wait_down: assert property (@(posedge pclk) disable iff (!presetn)
      (wait_mode && s_r.ctl[ADCPTC_B_WAIT_MODE_POWER_DOWN]) |=> !converter_power_on)
      else $error("converter ran in wait mode");
   chk_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
      (s_r.ctl[ADCPTC_B_SIE] && s_r.sequence_complete_flag) |-> irq)
      else $error("sequence irq missing");
   chk_flag_read: assert property (@(posedge pclk) disable iff (!presetn)
      (rd && paddr == ADCPTC_OFF_CTL2) |=>
      prdata[0] == ($past(s_r.ctl[ADCPTC_B_SIE]) && $past(s_r.sequence_complete_flag)))
      else $error("irq flag view wrong");
   chk_buf_en: assert property (@(posedge pclk) disable iff (!presetn)
      (s_r.ctl[ADCPTC_B_TEN] && !s_r.tsel[ADCPTC_B_TSRC]) |=>
      digital_buffer_en[$past(s_r.tsel[3:0])])
      else $error("trigger channel buffer off");
   chk_no_trig_off: assert property (@(posedge pclk) disable iff (!presetn)
      !s_r.ctl[ADCPTC_B_TEN] |=> !conv_start)
      else $error("start without trigger enable");
   chk_fast_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (rd && s_r.ctl[ADCPTC_B_FAST_FLAG_CLEAR] && paddr == ADCPTC_OFF_RESULT
       && !conv_done) |=> !s_r.ccf[0])
      else $error("fast clear failed");
   chk_sync_edge: assert property (@(posedge pclk) disable iff (!presetn)
      conv_start |-> $past(s_r.ctl[ADCPTC_B_TEN]))
      else $error("start from unarmed trigger");

   chk_abort_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      conv_abort |=> !conv_abort)
      else $error("abort longer than one cycle");

   chk_busy_cleared: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && paddr == ADCPTC_OFF_CTL2) |=> !s_r.busy)
      else $error("sequence still busy after control write");

   chk_power_on: assert property (@(posedge pclk) disable iff (!presetn)
      (s_r.ctl[ADCPTC_B_PWR] && !wait_mode) |=> converter_power_on)
      else $error("converter off while power bit set");

   chk_wait_run: assert property (@(posedge pclk) disable iff (!presetn)
      (s_r.ctl[ADCPTC_B_PWR] && !s_r.ctl[ADCPTC_B_WAIT_MODE_POWER_DOWN]) |=>
      converter_power_on)
      else $error("converter halted with wait power down clear");

   chk_wait_resume: assert property (@(posedge pclk) disable iff (!presetn)
      (s_r.ctl[ADCPTC_B_PWR] && !wait_mode && $past(wait_mode)) |=>
      converter_power_on)
      else $error("converter did not resume after wait");

   chk_halt_flags: assert property (@(posedge pclk) disable iff (!presetn)
      (conv_done && !run_ok && !acc) |=> s_r.ccf == $past(s_r.ccf))
      else $error("flag set while converter halted");

   chk_ccf_set: assert property (@(posedge pclk) disable iff (!presetn)
      (conv_done && run_ok && !acc) |=> s_r.ccf[$past(conv_ch)])
      else $error("conversion flag not set");

   chk_normal_keep: assert property (@(posedge pclk) disable iff (!presetn)
      (rd && res_acc && !s_r.ctl[ADCPTC_B_FAST_FLAG_CLEAR] &&
       !s_r.stat_seen[res_idx] && !conv_done) |=> s_r.ccf == $past(s_r.ccf))
      else $error("flag cleared without status read");

   chk_normal_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (rd && res_acc && s_r.stat_seen[res_idx]) |=> !s_r.ccf[$past(res_idx)])
      else $error("flag kept after status then result read");

   chk_stat_arms: assert property (@(posedge pclk) disable iff (!presetn)
      (rd && paddr == ADCPTC_OFF_STAT) |=> s_r.stat_seen == $past(s_r.ccf))
      else $error("status read did not arm flag clear");

   chk_fast_any: assert property (@(posedge pclk) disable iff (!presetn)
      (acc && res_acc && s_r.ctl[ADCPTC_B_FAST_FLAG_CLEAR]) |=> !s_r.ccf[$past(res_idx)])
      else $error("fast clear missed a result access");

   chk_fall_edge: assert property (@(posedge pclk) disable iff (!presetn)
      (s_r.ctl[4:3] == 2'b00 && s_r.ctl[ADCPTC_B_TEN] && s_r.trig_d &&
       !s_r.trig_s2 && run_ok && !s_r.busy && !acc) |=> conv_start)
      else $error("falling edge not detected");

   chk_rise_edge: assert property (@(posedge pclk) disable iff (!presetn)
      (s_r.ctl[4:3] == 2'b01 && s_r.ctl[ADCPTC_B_TEN] && !s_r.trig_d &&
       s_r.trig_s2 && run_ok && !s_r.busy && !acc) |=> conv_start)
      else $error("rising edge not detected");

   chk_low_level: assert property (@(posedge pclk) disable iff (!presetn)
      (s_r.ctl[4:3] == 2'b10 && s_r.ctl[ADCPTC_B_TEN] && !s_r.trig_s2 &&
       run_ok && !s_r.busy && !acc) |=> conv_start)
      else $error("low level not detected");

   chk_high_level: assert property (@(posedge pclk) disable iff (!presetn)
      (s_r.ctl[4:3] == 2'b11 && s_r.ctl[ADCPTC_B_TEN] && s_r.trig_s2 &&
       run_ok && !s_r.busy && !acc) |=> conv_start)
      else $error("high level not detected");

   chk_no_edge: assert property (@(posedge pclk) disable iff (!presetn)
      (!s_r.ctl[ADCPTC_B_TLE] && s_r.trig_d == s_r.trig_s2) |=> !conv_start)
      else $error("edge trigger fired without an edge");

   chk_idle_only: assert property (@(posedge pclk) disable iff (!presetn)
      s_r.busy |=> !conv_start)
      else $error("start while sequence busy");

   chk_start_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      conv_start |=> !conv_start)
      else $error("start longer than one cycle");

   chk_no_power_go: assert property (@(posedge pclk) disable iff (!presetn)
      !run_ok |=> !conv_start)
      else $error("start while converter powered down");

   chk_buf_dedic: assert property (@(posedge pclk) disable iff (!presetn)
      s_r.tsel[ADCPTC_B_TSRC] |=> digital_buffer_en == '0)
      else $error("buffer enabled for dedicated trigger");

   chk_buf_unarmed: assert property (@(posedge pclk) disable iff (!presetn)
      !s_r.ctl[ADCPTC_B_TEN] |=> digital_buffer_en == '0)
      else $error("buffer enabled with trigger off");

   chk_irq_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      (!s_r.ctl[ADCPTC_B_SIE] && (s_r.irq_stat & s_r.irq_mask) == '0) |->
      !irq)
      else $error("interrupt without a cause");

   chk_flag_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (rd && paddr == ADCPTC_OFF_CTL2 && !s_r.ctl[ADCPTC_B_SIE]) |=>
      !prdata[0])
      else $error("irq flag visible while disabled");

   chk_flag_ro: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && paddr == ADCPTC_OFF_CTL2) |=> !s_r.ctl[ADCPTC_B_SIF])
      else $error("irq flag bit was written");

   chk_src_dedic: assert property (@(posedge pclk) disable iff (!presetn)
      s_r.tsel[ADCPTC_B_TSRC] |-> trig_raw == dedicated_trigger_input)
      else $error("dedicated trigger not selected");

   chk_src_chan: assert property (@(posedge pclk) disable iff (!presetn)
      !s_r.tsel[ADCPTC_B_TSRC] |-> trig_raw == an_digital[s_r.tsel[3:0]])
      else $error("trigger channel not selected");

   chk_sync_chain: assert property (@(posedge pclk) disable iff (!presetn)
      s_r.trig_s1 |=> s_r.trig_s2)
      else $error("synchroniser stage skipped");

   chk_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("ready longer than one cycle");

   chk_err_ready: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready)
      else $error("error without ready");
endmodule

/* dv/adcptc_trig_src.sv */
`timescale 1ns/1ps
// external trigger source; holds its level between commands
module adcptc_trig_src (
   input wire logic pclk,
   output logic trig
);
   initial trig = 1'b0;
   task automatic set_level(input logic v);
      @(posedge pclk);
      trig <= v;
   endtask
endmodule

/* dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
   import adcptc_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic pready, pslverr, err, trig, wait_mode = 0, conv_done = 0;
   logic seq_done = 0, conv_start, conv_abort, pwr, irq;
   logic [3:0] conv_ch = 4'h0;
   logic [15:0] an_digital = 16'h0000, dbuf;
   int bad_count = 0, cmp_count = 0, cyc = 0, starts = 0, aborts = 0, s0, a0;
   adcptc_trig_src src_u (.pclk(pclk), .trig(trig));
   adcptc_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .an_digital(an_digital), .dedicated_trigger_input(trig),
      .wait_mode(wait_mode), .conv_done(conv_done), .conv_ch(conv_ch),
      .seq_done(seq_done), .conv_start(conv_start), .conv_abort(conv_abort),
      .converter_power_on(pwr), .digital_buffer_en(dbuf), .irq(irq));
   initial begin
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      starts <= starts + int'(conv_start);
      aborts <= aborts + int'(conv_abort);
      if (cyc == 6000) begin
         bad_count++;
         end_of_test();
      end
   end
   task end_of_test;
      if (bad_count == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1 && ++n < 40);
      if (pready !== 1'b1) bad_count++;
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task pulse_done(input logic seq, input logic [3:0] ch);
      conv_ch <= ch;
      conv_done <= ~seq;
      seq_done <= seq;
      @(posedge pclk);
      conv_done <= 0;
      seq_done <= 0;
      repeat (2) @(posedge pclk);
   endtask
   task t_reset_map;
      apb(0, ADCPTC_OFF_CTL2, 0);
      chk("ctl reset", {24'h0, ADCPTC_CTL2_RST}, rd);
      chk("power off", 0, pwr);
      apb(0, 8'hFC, 0);
      chk("unmapped err", 1, err);
   endtask
   task t_trigger_modes;
      apb(1, ADCPTC_OFF_TRIGSEL, 32'h0000_0080);
      for (int m = 0; m < 4; m++) begin
         src_u.set_level(~m[0]);
         repeat (4) @(posedge pclk);
         apb(1, ADCPTC_OFF_CTL2, 32'h84 | (m << 3));
         s0 = starts;
         src_u.set_level(m[0]);
         repeat (8) @(posedge pclk);
         chk("one start", 1, starts - s0);
      end
      s0 = starts;
      a0 = aborts;
      apb(1, ADCPTC_OFF_CTL2, 32'h0000_0080);
      chk("abort on write", 1, aborts - a0);
      src_u.set_level(0);
      repeat (8) @(posedge pclk);
      chk("no start", 0, starts - s0);
      apb(1, ADCPTC_OFF_CTL2, 32'h0000_001C);
      src_u.set_level(1);
      repeat (8) @(posedge pclk);
      chk("unpowered", 0, starts - s0);
   endtask
   task t_buffer_wait;
      apb(1, ADCPTC_OFF_TRIGSEL, 32'h0000_0003);
      apb(1, ADCPTC_OFF_CTL2, 32'h0000_00A4);
      chk("buffer en", 32'h8, dbuf);
      wait_mode <= 1;
      repeat (3) @(posedge pclk);
      chk("wait power", 0, pwr);
      wait_mode <= 0;
      repeat (3) @(posedge pclk);
      chk("resume power", 1, pwr);
   endtask
   task t_irq;
      apb(1, ADCPTC_OFF_CTL2, 32'h0000_0081);
      pulse_done(1, 0);
      apb(0, ADCPTC_OFF_CTL2, 0);
      chk("flag masked", 32'h80, rd);
      chk("irq quiet", 0, irq);
      apb(1, ADCPTC_OFF_IRQ_MASK, 1);
      chk("irq mask", 1, irq);
      apb(1, ADCPTC_OFF_IRQ_STAT, 1);
      chk("irq w1c", 0, irq);
      apb(1, ADCPTC_OFF_CTL2, 32'h0000_0082);
      apb(0, ADCPTC_OFF_CTL2, 0);
      chk("flag read", 32'h83, rd);
      chk("irq seq", 1, irq);
   endtask
   task t_flags;
      apb(1, ADCPTC_OFF_CTL2, 32'h0000_0080);
      pulse_done(0, 1);
      apb(0, ADCPTC_OFF_RESULT + 8'h04, 0);
      apb(0, ADCPTC_OFF_STAT, 0);
      chk("ccf kept", 1, rd[1]);
      apb(0, ADCPTC_OFF_RESULT + 8'h04, 0);
      apb(0, ADCPTC_OFF_STAT, 0);
      chk("ccf normal", 0, rd[1]);
      apb(1, ADCPTC_OFF_CTL2, 32'h0000_00C0);
      pulse_done(0, 2);
      apb(0, ADCPTC_OFF_RESULT + 8'h08, 0);
      apb(0, ADCPTC_OFF_STAT, 0);
      chk("ccf fast", 0, rd[2]);
      pulse_done(0, 3);
      apb(1, ADCPTC_OFF_RESULT + 8'h0C, 0);
      apb(0, ADCPTC_OFF_STAT, 0);
      chk("ccf fast write", 0, rd[3]);
   endtask
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      t_reset_map();
      t_trigger_modes();
      t_buffer_wait();
      t_irq();
      t_flags();
      end_of_test();
   end
endmodule
